/* File: common/smsc_pkg.sv */
package smsc_pkg;
   // strap ratio code width, thousandths of supply
   localparam int RATIO_W = 10;
   // mode strap bands
   localparam logic [RATIO_W-1:0] MODE0_MAX = 10'h085;
   localparam logic [RATIO_W-1:0] MODE2_MIN = 10'h120;
   localparam logic [RATIO_W-1:0] MODE2_MAX = 10'h16F;
   localparam logic [RATIO_W-1:0] MODE3_MIN = 10'h19C;
   localparam logic [RATIO_W-1:0] MODE3_MAX = 10'h1DA;
   localparam logic [RATIO_W-1:0] MODE5_MIN = 10'h282;
   localparam logic [RATIO_W-1:0] MODE5_MAX = 10'h2C0;
   // address strap bands
   localparam logic [RATIO_W-1:0] IDX1_MAX  = 10'h083;
   localparam logic [RATIO_W-1:0] IDX2_MIN  = 10'h0B2;
   localparam logic [RATIO_W-1:0] IDX2_MAX  = 10'h100;
   localparam logic [RATIO_W-1:0] IDX3_MIN  = 10'h219;
   localparam logic [RATIO_W-1:0] IDX3_MAX  = 10'h24F;
   localparam logic [RATIO_W-1:0] IDX4_MIN  = 10'h28C;
   localparam logic [RATIO_W-1:0] IDX4_MAX  = 10'h2C2;
   // mode codes
   localparam logic [2:0] MODE_SYNC = 3'h0;
   localparam logic [2:0] MODE_EXT  = 3'h2;
   localparam logic [2:0] MODE_INT  = 3'h3;
   localparam logic [2:0] MODE_PVC  = 3'h5;
   // address strap levels, none when out of band
   localparam logic [2:0] LVL_NONE  = 3'h0;
   localparam logic [2:0] LVL1      = 3'h1;
   localparam logic [2:0] LVL2      = 3'h2;
   localparam logic [2:0] LVL3      = 3'h3;
   localparam logic [2:0] LVL4      = 3'h4;
   // control-bus addresses
   localparam logic [6:0] ADDR_LO   = 7'h18;
   localparam logic [6:0] ADDR_HI   = 7'h19;
   // forward-channel reference sources
   localparam logic [1:0] REF_BACK  = 2'h0;
   localparam logic [1:0] REF_EXT   = 2'h1;
   localparam logic [1:0] REF_AON   = 2'h2;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_MODE   = 8'h03;
   localparam logic [7:0] IDX_CLKCFG = 8'h06;
   localparam logic [7:0] IDX_CLKDEN = 8'h07;
   localparam logic [7:0] IDX_STRAP  = 8'h08;
   // field positions
   localparam int MODE_MSB    = 2;
   localparam int OVR_BIT     = 4;
   localparam int CFG_M_MSB   = 4;
   localparam int CFG_DIV_LSB = 5;
   localparam int CFG_DIV_MSB = 7;
   localparam int HTRANS_ACT  = 1;
   // reset values
   localparam logic [4:0] CLK_M_RST   = 5'h01;
   localparam logic [2:0] CLK_DIV_RST = 3'h2;
   localparam logic [7:0] CLK_DEN_RST = 8'h1E;
   // divided forward-channel ceiling
   localparam int FC_DIV_LIMIT_MHZ = 1050;
   // power-up phase, gray along off, sense, drive
   typedef enum logic [1:0] {PH_OFF = 2'h0, PH_SENSE = 2'h1, PH_DRIVE = 2'h3} smsc_phase_t;
   // decoded straps
   typedef struct packed {
      logic [2:0] mode;
      logic       mode_ok;
      logic [2:0] idx_lvl;
      logic [6:0] bus_addr;
      logic       io_3v3;
   } smsc_strap_t;
endpackage

/* File: core/smsc_frac_clkgen.sv */
`timescale 1ns/1ps
module smsc_frac_clkgen
   import smsc_pkg::*;
#(
   parameter int M_W = 5,
   parameter int N_W = 8,
   parameter int D_W = 3
) (
   // clock and reset
   input  wire logic           i_ref_clk,
   input  wire logic           i_arst_n,
   input  wire logic           i_clk_en,
   // control
   input  wire logic           i_run,
   input  wire logic           i_tick,
   input  wire logic [D_W-1:0] i_div_code,
   input  wire logic [M_W-1:0] i_num,
   input  wire logic [N_W-1:0] i_den,
   // generated clock
   output logic                o_clk
);
   localparam int DC_W = 1 << D_W;

   typedef struct packed {
      logic [DC_W-1:0] dcnt;
      logic [N_W:0]    acc;
      logic            clk;
   } smsc_fstate_t;

   smsc_fstate_t    st;
   smsc_fstate_t    next_st;
   logic            hs_last;
   logic [N_W:0]    sum;

   // divider by two to the code, then add twice the numerator modulo the denominator
   always_comb begin
      next_st = st;
      hs_last = (st.dcnt == DC_W'((1 << i_div_code) - 1));
      sum     = st.acc + (N_W+1)'({i_num, 1'b0});
      if (!i_run) begin
         next_st = '0;
      end else if (i_tick) begin
         if (hs_last) begin
            next_st.dcnt = '0;
            if (i_den != '0) begin
               if (sum >= {1'b0, i_den}) begin
                  next_st.acc = sum - {1'b0, i_den};
                  next_st.clk = ~st.clk;
               end else begin
                  next_st.acc = sum;
               end
            end
         end else begin
            next_st.dcnt = st.dcnt + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else if (i_clk_en) begin
         st <= next_st;
      end
   end

   assign o_clk = st.clk;
endmodule

/* File: core/smsc_strap_decode.sv */
`timescale 1ns/1ps
module smsc_strap_decode
   import smsc_pkg::*;
(
   // strap ratio codes
   input  wire logic [RATIO_W-1:0] i_mode_ratio,
   input  wire logic [RATIO_W-1:0] i_idx_ratio,
   // decoded result
   output smsc_strap_t             o_strap
);
   smsc_strap_t s;

   // band compare on both straps
   always_comb begin
      s = '0;
      if (i_mode_ratio <= MODE0_MAX) begin
         s.mode    = MODE_SYNC;
         s.mode_ok = 1'b1;
      end else if (i_mode_ratio >= MODE2_MIN && i_mode_ratio <= MODE2_MAX) begin
         s.mode    = MODE_EXT;
         s.mode_ok = 1'b1;
      end else if (i_mode_ratio >= MODE3_MIN && i_mode_ratio <= MODE3_MAX) begin
         s.mode    = MODE_INT;
         s.mode_ok = 1'b1;
      end else if (i_mode_ratio >= MODE5_MIN && i_mode_ratio <= MODE5_MAX) begin
         s.mode    = MODE_PVC;
         s.mode_ok = 1'b1;
      end
      if (i_idx_ratio <= IDX1_MAX) begin
         s.idx_lvl = LVL1;
      end else if (i_idx_ratio >= IDX2_MIN && i_idx_ratio <= IDX2_MAX) begin
         s.idx_lvl = LVL2;
      end else if (i_idx_ratio >= IDX3_MIN && i_idx_ratio <= IDX3_MAX) begin
         s.idx_lvl = LVL3;
      end else if (i_idx_ratio >= IDX4_MIN && i_idx_ratio <= IDX4_MAX) begin
         s.idx_lvl = LVL4;
      end
      // even levels take the upper address, upper levels 3.3 v
      s.bus_addr = (s.idx_lvl == LVL2 || s.idx_lvl == LVL4) ? ADDR_HI : ADDR_LO;
      s.io_3v3   = (s.idx_lvl == LVL3 || s.idx_lvl == LVL4);
   end

   assign o_strap = s;
endmodule

/* File: core/smsc_top.sv */
// Operation
// - clock is rate times m over divider times n
// - internal oscillator mode disables sensor clock
// - sync and external modes drive sensor clock
// - default mode comes from mode strap
// - mode readable and changeable by register
// - code zero: synchronous, back-channel reference
// - code two: external reference clock input
// - code three: always-on oscillator reference
// - code five: parallel video, no low-frequency format
// - address strap sensed at power-up
// - pin switches to clock after configuration
// - strap level picks address and io voltage
// - mode latched on power enable rising
// - mode field writable only with override
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module smsc_top
   import smsc_pkg::*;
#(
   parameter int FC_RATE_MHZ = 4000
) (
   // clock, reset, enable
   input  wire logic               i_ref_clk,
   input  wire logic               i_arst_n,
   input  wire logic               i_clk_en,
   // power enable, straps, forward-channel tick
   input  wire logic               i_pwr_en,
   input  wire logic [RATIO_W-1:0] i_mode_ratio,
   input  wire logic [RATIO_W-1:0] i_idx_ratio,
   input  wire logic               i_fc_tick,
   // ahb-lite slave
   input  wire logic               i_hsel,
   input  wire logic [31:0]        i_haddr,
   input  wire logic [1:0]         i_htrans,
   input  wire logic               i_hwrite,
   input  wire logic [2:0]         i_hsize,
   input  wire logic [31:0]        i_hwdata,
   input  wire logic               i_hready,
   output logic [31:0]             o_hrdata,
   output logic                    o_hreadyout,
   output logic                    o_hresp,
   // shared clock-out pin
   output logic                    o_clkout,
   output logic                    o_clkout_oe,
   // configuration results
   output logic [6:0]              o_bus_addr,
   output logic                    o_io_3v3,
   output logic [1:0]              o_ref_src,
   output logic                    o_pvc_mode,
   output logic                    o_lf12_ok
);
   typedef struct packed {
      smsc_phase_t phase;
      logic        pwr_q;
      logic [2:0]  mode;
      logic        ovr;
      logic [4:0]  clk_m;
      logic [2:0]  clk_div;
      logic [7:0]  clk_den;
      smsc_strap_t strap;
      logic        wr_pend;
      logic [29:0] wr_word;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic        clkout;
      logic        oe;
      logic [1:0]  ref_src;
      logic        pvc;
      logic        lf12_ok;
   } smsc_state_t;

   smsc_state_t st;
   smsc_state_t next_st;
   smsc_strap_t dec;
   logic        frac_clk;
   logic        frac_run;
   logic        hit;
   logic [29:0] word;
   logic        div_fault;
   logic [31:0] rdat;

   // strap decoder
   smsc_strap_decode u_dec (
      .i_mode_ratio (i_mode_ratio),
      .i_idx_ratio  (i_idx_ratio),
      .o_strap      (dec)
   );

   // fractional clock generator
   smsc_frac_clkgen #(
      .M_W (5),
      .N_W (8),
      .D_W (3)
   ) u_gen (
      .i_ref_clk  (i_ref_clk),
      .i_arst_n   (i_arst_n),
      .i_clk_en   (i_clk_en),
      .i_run      (frac_run),
      .i_tick     (i_fc_tick),
      .i_div_code (st.clk_div),
      .i_num      (st.clk_m),
      .i_den      (st.clk_den),
      .o_clk      (frac_clk)
   );

   // bus decode and generator enable
   assign hit       = i_hsel && i_htrans[HTRANS_ACT] && i_hready;
   assign word      = i_haddr[31:2];
   assign frac_run  = (st.phase == PH_DRIVE) && (st.mode != MODE_INT);
   assign div_fault = (FC_RATE_MHZ >> st.clk_div) >= FC_DIV_LIMIT_MHZ;

   // read multiplexer, unmapped words read zero
   always_comb begin
      rdat = '0;
      case (word)
         30'(IDX_MODE): begin
            rdat = 32'({st.ovr, 1'b0, st.mode});
         end
         30'(IDX_CLKCFG): begin
            rdat = 32'({st.clk_div, st.clk_m});
         end
         30'(IDX_CLKDEN): begin
            rdat = 32'(st.clk_den);
         end
         30'(IDX_STRAP): begin
            rdat = 32'({div_fault, st.strap});
         end
         default: begin
            rdat = '0;
         end
      endcase
   end

   // next state
   always_comb begin
      next_st           = st;
      next_st.pwr_q     = i_pwr_en;
      next_st.hreadyout = 1'b1;
      next_st.hresp     = 1'b0;
      // address phase capture, zero-wait read data
      next_st.wr_pend   = hit && i_hwrite;
      next_st.wr_word   = hit ? word : st.wr_word;
      next_st.hrdata    = (hit && !i_hwrite) ? rdat : '0;
      // data phase write
      if (st.wr_pend) begin
         case (st.wr_word)
            30'(IDX_MODE): begin
               next_st.ovr = i_hwdata[OVR_BIT];
               if (i_hwdata[OVR_BIT]) begin
                  next_st.mode = i_hwdata[MODE_MSB:0];
               end
            end
            30'(IDX_CLKCFG): begin
               next_st.clk_m   = i_hwdata[CFG_M_MSB:0];
               next_st.clk_div = i_hwdata[CFG_DIV_MSB:CFG_DIV_LSB];
            end
            30'(IDX_CLKDEN): begin
               next_st.clk_den = i_hwdata[7:0];
            end
            default: begin
               next_st.clk_den = st.clk_den;
            end
         endcase
      end
      // power-up sequence
      case (st.phase)
         PH_OFF: begin
            if (i_pwr_en && !st.pwr_q) begin
               next_st.phase = PH_SENSE;
               next_st.strap = dec;
               next_st.mode  = dec.mode;
               next_st.ovr   = 1'b0;
            end
         end
         PH_SENSE: begin
            next_st.phase = PH_DRIVE;
         end
         PH_DRIVE: begin
            next_st.phase = PH_DRIVE;
         end
         default: begin
            next_st.phase = PH_OFF;
         end
      endcase
      if (!i_pwr_en) begin
         next_st.phase = PH_OFF;
      end
      // pin drive: enabled in the drive phase, clock in every mode except internal, static low otherwise
      next_st.oe     = (next_st.phase == PH_DRIVE);
      // gate on the next phase so a power drop never leaves a stray edge on the pin
      next_st.clkout = (frac_run && next_st.oe) ? frac_clk : 1'b0;
      // reference source from active mode
      case (next_st.mode)
         MODE_EXT: begin
            next_st.ref_src = REF_EXT;
         end
         MODE_PVC: begin
            next_st.ref_src = REF_EXT;
         end
         MODE_INT: begin
            next_st.ref_src = REF_AON;
         end
         default: begin
            next_st.ref_src = REF_BACK;
         end
      endcase
      next_st.pvc     = (next_st.mode == MODE_PVC);
      next_st.lf12_ok = (next_st.mode != MODE_PVC);
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st           <= '0;
         st.phase     <= PH_OFF;
         st.mode      <= MODE_SYNC;
         st.clk_m     <= CLK_M_RST;
         st.clk_div   <= CLK_DIV_RST;
         st.clk_den   <= CLK_DEN_RST;
         st.hreadyout <= 1'b1;
         st.ref_src   <= REF_BACK;
         st.lf12_ok   <= 1'b1;
      end else if (i_clk_en) begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign o_hrdata    = st.hrdata;
   assign o_hreadyout = st.hreadyout;
   assign o_hresp     = st.hresp;
   assign o_clkout    = st.clkout;
   assign o_clkout_oe = st.oe;
   assign o_bus_addr  = st.strap.bus_addr;
   assign o_io_3v3    = st.strap.io_3v3;
   assign o_ref_src   = st.ref_src;
   assign o_pvc_mode  = st.pvc;
   assign o_lf12_ok   = st.lf12_ok;

   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   a_mode_latch: assert property (
      (i_clk_en && st.phase == PH_OFF && i_pwr_en && !st.pwr_q)
      |=> (st.mode == $past(dec.mode) && st.phase == PH_SENSE))
      else $error("mode not latched at power enable");
   a_sense_drive: assert property (
      (i_clk_en && st.phase == PH_SENSE && i_pwr_en) |=> (o_clkout_oe && st.phase == PH_DRIVE))
      else $error("pin not switched to clock after sensing");
   a_off_sense: assert property (
      (i_clk_en && !i_pwr_en) |=> (!o_clkout_oe ##1 (!o_clkout_oe || i_pwr_en)))
      else $error("pin driven while powered down");
   a_int_quiet: assert property (
      (i_clk_en && st.mode == MODE_INT) |=> !o_clkout)
      else $error("clock output active in internal mode");
   a_static_hold: assert property (
      (i_clk_en && st.phase != PH_DRIVE) [*2] |-> !o_clkout)
      else $error("disabled clock output not static");
   a_clk_follow: assert property (
      (i_clk_en && i_pwr_en && st.phase == PH_DRIVE && st.mode != MODE_INT)
      |=> (o_clkout == $past(frac_clk)))
      else $error("clock output does not follow generator");
   a_mode_ro: assert property (
      (i_clk_en && st.wr_pend && st.wr_word == 30'(IDX_MODE) && !i_hwdata[OVR_BIT]
       && st.phase != PH_OFF) |=> $stable(st.mode))
      else $error("mode changed without override");
   a_mode_wr: assert property (
      (i_clk_en && st.wr_pend && st.wr_word == 30'(IDX_MODE) && i_hwdata[OVR_BIT]
       && st.phase != PH_OFF) |=> (st.mode == $past(i_hwdata[MODE_MSB:0]) && st.ovr))
      else $error("override write did not set mode");
   a_mode_rd: assert property (
      (i_clk_en && hit && !i_hwrite && word == 30'(IDX_MODE) && !st.wr_pend)
      |=> (o_hrdata[MODE_MSB:0] == $past(st.mode)))
      else $error("mode read back wrong");
   a_addr_lvl: assert property (
      (st.strap.idx_lvl == LVL2 || st.strap.idx_lvl == LVL4)
      |-> (o_bus_addr == ADDR_HI && (o_io_3v3 == (st.strap.idx_lvl == LVL4))))
      else $error("address strap decode wrong");
   a_ref_sync: assert property (
      (i_clk_en && st.wr_pend == 1'b0 && st.phase == PH_DRIVE && st.mode == MODE_SYNC)
      |=> (o_ref_src == REF_BACK || $past(i_pwr_en) == 1'b0))
      else $error("synchronous mode reference wrong");
   a_ref_ext: assert property (
      ((st.mode == MODE_EXT) |-> (o_ref_src == REF_EXT))
      and ((st.mode == MODE_INT) |-> (o_ref_src == REF_AON)))
      else $error("reference source wrong");
   a_pvc_fmt: assert property (
      (st.mode == MODE_PVC) |-> (o_pvc_mode && !o_lf12_ok && o_ref_src == REF_EXT))
      else $error("parallel video mode flags wrong");

   c_power_up: cover property (
      st.phase == PH_OFF ##1 st.phase == PH_SENSE ##1 st.phase == PH_DRIVE);
   c_override: cover property (
      st.wr_pend && st.wr_word == 30'(IDX_MODE) && i_hwdata[OVR_BIT]);
   c_int_mode: cover property (st.phase == PH_DRIVE && st.mode == MODE_INT);
   c_clk_edge: cover property (o_clkout_oe && $rose(o_clkout));
endmodule

/* File: sim/smsc_sensor_model.sv */
`timescale 1ns/1ps
module smsc_sensor_model (
   // clock, reset
   input  wire logic i_ref_clk,
   input  wire logic i_arst_n,
   // sensor clock pin and its enable
   input  wire logic i_pin,
   input  wire logic i_pin_oe,
   // edge counts seen by the sensor
   output int        o_edges,
   output int        o_idle_moves
);
   logic last;

   // count rising edges, driven and undriven apart
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         last <= 1'b0;
         o_edges <= 0;
         o_idle_moves <= 0;
      end else begin
         last <= i_pin;
         if (i_pin_oe && i_pin && !last) begin
            o_edges <= o_edges + 1;
         end
         if (!i_pin_oe && i_pin && !last) begin
            o_idle_moves <= o_idle_moves + 1;
         end
      end
   end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import smsc_pkg::*;
   localparam int FC = 4000;
   // drives
   logic               ref_clk, arst_n, pwr_en, fc_tick, hsel, hwrite, clk_en;
   logic [RATIO_W-1:0] mode_ratio, idx_ratio;
   logic [31:0]        haddr, hwdata, rd;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   // design outputs
   logic [31:0]        hrdata;
   logic               hreadyout, hresp, clkout, clkout_oe, io_3v3, pvc_mode, lf12_ok;
   logic [6:0]         bus_addr;
   logic [1:0]         ref_src;
   // bench model state
   int                 fail_count, comparisons, edges, idle_moves, ticks, seed, m, dc, n;
   int                 mr[5] = '{0, 288, 474, 704, 200};
   int                 ir[5] = '{0, 256, 537, 679, 400};
   int                 md[5] = '{0, 2, 3, 5, 0};
   int                 lv[5] = '{1, 2, 3, 4, 0};
   int                 ov[4] = '{3, 5, 2, 0};

   smsc_top #(.FC_RATE_MHZ(FC)) u_smsc_top (
      .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_clk_en(clk_en), .i_pwr_en(pwr_en),
      .i_mode_ratio(mode_ratio), .i_idx_ratio(idx_ratio), .i_fc_tick(fc_tick),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .o_clkout(clkout),
      .o_clkout_oe(clkout_oe), .o_bus_addr(bus_addr), .o_io_3v3(io_3v3),
      .o_ref_src(ref_src), .o_pvc_mode(pvc_mode), .o_lf12_ok(lf12_ok));

   smsc_sensor_model u_smsc_sensor_model (
      .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_pin(clkout), .i_pin_oe(clkout_oe),
      .o_edges(edges), .o_idle_moves(idle_moves));

   // 200 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // random forward-channel ticks, counted as the design samples them
   always @(posedge ref_clk) begin
      if (fc_tick === 1'b1) begin
         ticks <= ticks + 1;
      end
      fc_tick <= ($random(seed) % 2) != 0;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask

   task automatic test_done();
      $display("counts: %0d compared, %0d mismatched", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // wait for hready sampled high, catching read data
   task automatic wt(output logic [31:0] r);
      int   i;
      logic rdy;
      i = 0;
      do begin
         @(negedge ref_clk);
         rdy = hreadyout;
         r = hrdata;
         @(posedge ref_clk);
         i++;
      end while (rdy !== 1'b1 && i < 50);
      if (rdy !== 1'b1) begin
         $display("MISMATCH t=%0t bus hang", $time);
         fail_count++;
         test_done();
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wt(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt(rd);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask

   task automatic pwr(input int k);
      @(posedge ref_clk);
      mode_ratio <= RATIO_W'(mr[k]);
      idx_ratio <= RATIO_W'(ir[k]);
      pwr_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      pwr_en <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   // edges over a window against ticks times m over divider times n
   task automatic clk_chk(input bit run);
      int e0, t0, x;
      e0 = edges;
      t0 = ticks;
      repeat (600) @(posedge ref_clk);
      x = run ? (ticks - t0) * m / ((1 << dc) * n) : 0;
      chk(32'(edges - e0 >= x - 2 && edges - e0 <= x + 2), 32'h0000_0001);
   endtask

   task automatic exp_mode(input int c);
      logic [1:0] rs;
      rs = (c == 2 || c == 5) ? REF_EXT : (c == 3) ? REF_AON : REF_BACK;
      @(negedge ref_clk);
      chk(32'(ref_src), 32'(rs));
      chk(32'(pvc_mode), 32'(c == 5));
      chk(32'(lf12_ok), 32'(c != 5));
      if (c != 3) chk(32'(clkout_oe), 32'h0000_0001);
      clk_chk(c != 3);
   endtask

   // integer ratio n over m, random divider
   task automatic cfg();
      m = 1 + $unsigned($random(seed)) % 4;
      dc = $unsigned($random(seed)) % 4;
      n = 2 * m * (1 + $unsigned($random(seed)) % 3);
      ahb(1'b1, 32'h0000_0018, 32'(dc * 32 + m));
      ahb(1'b1, 32'h0000_001C, 32'(n));
      rdchk(32'h0000_0018, 32'(dc * 32 + m));
   endtask

   initial begin
      int k, a, st;
      seed = 32'h9665_744a;
      {arst_n, pwr_en, fc_tick, hsel, hwrite, htrans} = '0;
      {mode_ratio, idx_ratio, haddr, hwdata} = '0;
      hsize = 3'h2;
      clk_en = 1'b1;
      m = 1;
      dc = 2;
      n = 30;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      chk({hreadyout, hresp, clkout_oe, clkout, lf12_ok}, 32'h0000_0011);
      rdchk(32'h0000_000C, 32'h0000_0000);
      rdchk(32'h0000_0018, 32'h0000_0041);
      rdchk(32'h0000_001C, 32'h0000_001E);
      $display("test reset done");
      // strap table at band edges, index level four mid-band, plus one out-of-band pair
      for (k = 0; k < 5; k++) begin
         cfg();
         pwr(k);
         a = (lv[k] == 2 || lv[k] == 4) ? 'h19 : 'h18;
         st = ((FC >> dc) >= 1050) << 15 | md[k] << 12 | (k != 4) << 11 | lv[k] << 8;
         st = st | a << 1 | (lv[k] >= 3);
         @(negedge ref_clk);
         chk(32'(bus_addr), 32'(a));
         chk(32'(io_3v3), 32'(lv[k] >= 3));
         rdchk(32'h0000_000C, 32'(md[k]));
         rdchk(32'h0000_0020, 32'(st));
         exp_mode(md[k]);
      end
      $display("test straps done");
      ahb(1'b1, 32'h0000_000C, 32'h0000_0003);
      rdchk(32'h0000_000C, 32'h0000_0000);
      for (k = 0; k < 4; k++) begin
         ahb(1'b1, 32'h0000_000C, 32'(16 + ov[k]));
         rdchk(32'h0000_000C, 32'(16 + ov[k]));
         exp_mode(ov[k]);
      end
      $display("test override done");
      ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
      rdchk(32'h0000_0040, 32'h0000_0000);
      pwr(1);
      rdchk(32'h0000_000C, 32'h0000_0002);
      $display("test repower done");
      // power drop while frozen must not act until the enable returns
      @(posedge ref_clk);
      clk_en <= 1'b0;
      pwr_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'(clkout_oe), 32'h0000_0001);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({clkout_oe, clkout}, 32'h0000_0000);
      clk_chk(1'b0);
      chk(32'(idle_moves), 32'h0000_0000);
      $display("test power off done");
      test_done();
   end
endmodule
